// File: sda_regs.svh
// timing counts and field positions of the converter serial control block
// assumes a single master clock that is also the logic clock
`ifndef SDA_REGS_SVH
`define SDA_REGS_SVH

`define SDA_WORD_BITS 20
`define SDA_LOAD_CYCLES 4
`define SDA_TRIM_MIN_CYCLES 4
`define SDA_CAL_CYCLES 64
`define SDA_SCLK_DIV 4
`define SDA_SCLK_HIGH_PH 0
`define SDA_CLK_PERIOD_NS 40
`define SDA_HOST_SETUP_NS 160
`define SDA_HOST_SETUP_CYC ((`SDA_HOST_SETUP_NS + `SDA_CLK_PERIOD_NS - 1) / `SDA_CLK_PERIOD_NS)
`define SDA_PIN_INIT 8'h82
`define SDA_PIN_SLEEP 7
`define SDA_PIN_POL 6
`define SDA_PIN_MODE 5
`define SDA_PIN_TRIM 4
`define SDA_PIN_TA 3
`define SDA_PIN_TB 2
`define SDA_PIN_SEL 1
`define SDA_PIN_SCLK 0

`endif

// File: sda_pkg.sv
// types shared by the converter serial control modules
// assumes sda_regs.svh is compiled alongside
package sda_pkg;
  typedef enum logic [1:0] {
    TS_RUN = 2'b00,
    TS_HELD = 2'b01,
    TS_RESET = 2'b10,
    TS_CAL = 2'b11
  } sda_trim_st_t;

  typedef enum logic {
    SH_IDLE = 1'b0,
    SH_RUN = 1'b1
  } sda_shf_st_t;
endpackage

// File: sda_shift_if.sv
// carrier between the control core and the serial shifter
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`include "sda_regs.svh"
interface sda_shift_if #(parameter int WORD_BITS = `SDA_WORD_BITS);
  logic start;
  logic [WORD_BITS-1:0] word;
  logic self_clk;
  logic sel_n;
  logic sclk_rise;
  logic sclk_fall;
  logic abort;
  logic busy;
  logic done;
  logic sdo;
  logic sclk_o;

  modport ctl (output start, word, self_clk, sel_n, sclk_rise, sclk_fall, abort,
               input busy, done, sdo, sclk_o);
  modport shf (input start, word, self_clk, sel_n, sclk_rise, sclk_fall, abort,
               output busy, done, sdo, sclk_o);
endinterface

// File: sda_sync.sv
// three-stage pin synchroniser; an output bit moves once stages two and three agree
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/1ps
module sda_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // pins and synchronised levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      // each bit keeps its own flop so no two processes share the output vector
      assign lvl[i] = lvl_q;
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          s1_q <= INIT[i];
          s2_q <= INIT[i];
          s3_q <= INIT[i];
          lvl_q <= INIT[i];
        end else begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // a glitch seen by only one stage never reaches the core
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
    end
  endgenerate
endmodule

// File: sda_shifter.sv
// 20-bit serial word shifter, msb first, self or externally clocked
// assumes sclk edges arrive already synchronised as one-cycle pulses
`timescale 1ns/1ps
`include "sda_regs.svh"
module sda_shifter #(
  parameter int WORD_BITS = `SDA_WORD_BITS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // control side
  sda_shift_if.shf sh
);
  import sda_pkg::*;

  localparam int CW = $clog2(WORD_BITS);

  sda_shf_st_t st_q;
  logic [WORD_BITS-1:0] sr_q;
  logic [CW-1:0] left_q;
  logic [1:0] ph_q;
  logic rose_q;
  logic bit_end;

  // end of the current bit: last divider phase, or falling sclk after a rise
  assign bit_end = sh.self_clk ? (ph_q == 2'(`SDA_SCLK_DIV - 1)) : (sh.sclk_fall && rose_q);
  assign sh.busy = (st_q == SH_RUN);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q <= SH_IDLE;
      sr_q <= '0;
      left_q <= '0;
      ph_q <= 2'h0;
      rose_q <= 1'b0;
      sh.sdo <= 1'b0;
      sh.sclk_o <= 1'b0;
      sh.done <= 1'b0;
    end else begin
      sh.done <= 1'b0;
      unique case (st_q)
        SH_IDLE: begin
          sh.sclk_o <= 1'b0;
          if (sh.start && !sh.abort) begin
            st_q <= SH_RUN;
            sr_q <= sh.word;
            sh.sdo <= sh.word[WORD_BITS-1];
            left_q <= CW'(WORD_BITS - 1);
            ph_q <= 2'h0;
            rose_q <= 1'b0;
          end
        end
        SH_RUN: begin
          ph_q <= ph_q + 2'h1;
          // one high phase in four gives a quarter-rate clock at 25% duty
          sh.sclk_o <= sh.self_clk && (ph_q == 2'(`SDA_SCLK_HIGH_PH));
          if (sh.sclk_rise) begin
            rose_q <= 1'b1;
          end
          if (sh.abort) begin
            st_q <= SH_IDLE;
            sh.sclk_o <= 1'b0;
          end else if (!sh.self_clk && sh.sel_n && !rose_q && !sh.sclk_rise) begin
            st_q <= SH_IDLE;
          end else if (bit_end) begin
            rose_q <= 1'b0;
            if (left_q == '0) begin
              st_q <= SH_IDLE;
              sh.done <= 1'b1;
            end else if (sh.sel_n) begin
              st_q <= SH_IDLE;
            end else begin
              sr_q <= {sr_q[WORD_BITS-2:0], 1'b0};
              sh.sdo <= sr_q[WORD_BITS-2];
              left_q <= left_q - CW'(1);
            end
          end
        end
      endcase
    end
  end
endmodule

// File: sda_ctrl.sv
// digital control and serial readout of a 20-bit sigma-delta converter
// assumes ref_clk is the master clock and conv_word arrives from the filter on it
//
// Overview of operation
// - sleep low suspends work, low power
// - polarity low unipolar, high bipolar range
// - trim request held over 4 cycles resets
// - calibration begins on trim request falling edge
// - select low starts shifting the serial word
// - valid flag low while unread word held
// - valid flag high after complete word sent
// - valid flag high four cycles during load
// - mode input sets serial clock pin direction
// - self clock is quarter rate, 25% high
// - each result leaves as 20-bit serial word
// - mode low external msb first, high self
// - early deselect finishes bit, releases pins
// - select ignored in load window; host waits (here a select in the window is held off and starts the word when it closes)
// - trim type pins sampled on request rise
`timescale 1ns/1ps
`include "sda_regs.svh"
module sda_ctrl #(
  parameter int WORD_BITS = `SDA_WORD_BITS,
  parameter int CAL_CYCLES = `SDA_CAL_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // static control pins
  input wire logic sleep_n,
  input wire logic polarity_select,
  input wire logic self_clocked_mode,
  // calibration pins
  input wire logic trim_request,
  input wire logic trim_type_a,
  input wire logic trim_type_b,
  // serial port
  input wire logic device_select_n,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  output logic serial_out,
  output logic serial_out_oe,
  output logic word_valid_n,
  // filter side
  input wire logic [WORD_BITS-1:0] conv_word,
  input wire logic conv_strobe,
  // status to the converter core
  output logic low_power,
  output logic bipolar_mode,
  output logic device_reset,
  output logic trim_start,
  output logic trim_busy,
  output logic [1:0] trim_kind
);
  import sda_pkg::*;

  logic [7:0] pin_lvl;
  logic sleep_s;
  logic pol_s;
  logic mode_s;
  logic trim_s;
  logic sel_s;
  logic sclk_s;
  logic sclk_prev_q;
  logic trim_prev_q;
  sda_trim_st_t tst_q;
  logic [2:0] tcnt_q;
  logic [15:0] ccnt_q;
  logic [2:0] win_q;
  logic [WORD_BITS-1:0] pend_q;
  logic [WORD_BITS-1:0] out_q;
  logic unread_q;
  logic arm_q;
  logic run_ok;
  logic start;
  logic trim_rise;
  logic held_long;
  logic cal_last;
  logic load_take;

  sda_shift_if #(.WORD_BITS(WORD_BITS)) sh ();

  // every pin, static or not, is resynchronised; sclk is sampled like any other input
  sda_sync #(
    .W(8),
    .INIT(`SDA_PIN_INIT)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin({sleep_n, polarity_select, self_clocked_mode, trim_request,
          trim_type_a, trim_type_b, device_select_n, sclk_in}),
    .lvl(pin_lvl)
  );

  assign sleep_s = pin_lvl[`SDA_PIN_SLEEP];
  assign pol_s = pin_lvl[`SDA_PIN_POL];
  assign mode_s = pin_lvl[`SDA_PIN_MODE];
  assign trim_s = pin_lvl[`SDA_PIN_TRIM];
  assign sel_s = pin_lvl[`SDA_PIN_SEL];
  assign sclk_s = pin_lvl[`SDA_PIN_SCLK];

  assign low_power = !sleep_s;
  assign bipolar_mode = pol_s;
  assign device_reset = (tst_q == TS_RESET);
  assign trim_busy = (tst_q == TS_CAL);
  assign run_ok = !low_power && (tst_q == TS_RUN || tst_q == TS_HELD);

  // result coding: offset binary flips the top bit, unipolar clamps below ground
  function automatic logic [WORD_BITS-1:0] sda_code(input logic [WORD_BITS-1:0] w,
                                                   input logic bip);
    if (bip) begin
      sda_code = {~w[WORD_BITS-1], w[WORD_BITS-2:0]};
    end else if (w[WORD_BITS-1]) begin
      sda_code = '0;
    end else begin
      sda_code = w;
    end
  endfunction

  // level pair to edge pulse, shared by the request and sclk detectors
  function automatic logic rise_of(input logic cur, input logic prev);
    rise_of = cur && !prev;
  endfunction

  // sclk edge detector; resets to the idle low level so no false edge follows reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // request edge detector
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trim_prev_q <= 1'b0;
    end else begin
      trim_prev_q <= trim_s;
    end
  end

  assign trim_rise = rise_of(trim_s, trim_prev_q);
  assign held_long = (tcnt_q == 3'(`SDA_TRIM_MIN_CYCLES));
  assign cal_last = (ccnt_q == 16'(CAL_CYCLES - 1));

  // calibration request state
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tst_q <= TS_RUN;
    end else begin
      unique case (tst_q)
        TS_RUN: begin
          if (trim_rise) begin
            tst_q <= TS_HELD;
          end
        end
        TS_HELD: begin
          if (!trim_s) begin
            tst_q <= TS_RUN;
          end else if (held_long) begin
            tst_q <= TS_RESET;
          end
        end
        TS_RESET: begin
          // all parts released together start in step, so a shared strobe aligns them
          if (!trim_s) begin
            tst_q <= TS_CAL;
          end
        end
        TS_CAL: begin
          if (cal_last) begin
            tst_q <= TS_RUN;
          end
        end
      endcase
    end
  end

  // hold counter: synchronised high cycles of the request, saturating at the limit
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tcnt_q <= 3'h0;
    end else if (tst_q == TS_RUN && trim_rise) begin
      tcnt_q <= 3'h1;
    end else if (tst_q == TS_HELD && trim_s && !held_long) begin
      tcnt_q <= tcnt_q + 3'h1;
    end
  end

  // calibration length counter, cleared while the part is held in reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ccnt_q <= 16'h0000;
    end else if (tst_q == TS_RESET) begin
      ccnt_q <= 16'h0000;
    end else if (tst_q == TS_CAL && !cal_last) begin
      ccnt_q <= ccnt_q + 16'h0001;
    end
  end

  // calibration type latched at request rise
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trim_kind <= 2'h0;
    end else if (tst_q == TS_RUN && trim_rise) begin
      trim_kind <= {pin_lvl[`SDA_PIN_TB], pin_lvl[`SDA_PIN_TA]};
    end
  end

  // one-cycle start pulse as the request is released after a reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trim_start <= 1'b0;
    end else begin
      trim_start <= (tst_q == TS_RESET) && !trim_s;
    end
  end

  // a result is taken only outside the window; trim reset already blocks run_ok
  assign load_take = conv_strobe && run_ok && (win_q == 3'h0);

  // four-cycle load window countdown
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      win_q <= 3'h0;
    end else if (device_reset) begin
      win_q <= 3'h0;
    end else if (win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end else if (load_take) begin
      win_q <= 3'(`SDA_LOAD_CYCLES);
    end
  end

  // coded result waits here until the window closes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pend_q <= '0;
    end else if (load_take) begin
      pend_q <= sda_code(conv_word, pol_s);
    end
  end

  // output register changes only at the window end, even while a word is being shifted out
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      out_q <= '0;
    end else if (!device_reset && win_q == 3'h1) begin
      out_q <= pend_q;
    end
  end

  // unread flag: a new word wins over a transfer ending the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      unread_q <= 1'b0;
    end else if (device_reset) begin
      unread_q <= 1'b0;
    end else if (win_q == 3'h1) begin
      unread_q <= 1'b1;
    end else if (sh.done) begin
      unread_q <= 1'b0;
    end
  end

  assign word_valid_n = !unread_q || (win_q != 3'h0) || low_power;

  // select is level-taken once per assertion and held off through the load window
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      arm_q <= 1'b0;
    end else if (sel_s) begin
      arm_q <= 1'b1;
    end else if (start) begin
      arm_q <= 1'b0;
    end
  end

  assign start = !sel_s && arm_q && (win_q == 3'h0) && run_ok && !sh.busy;

  assign sh.start = start;
  assign sh.word = out_q;
  assign sh.self_clk = mode_s;
  assign sh.sel_n = sel_s;
  assign sh.sclk_rise = rise_of(sclk_s, sclk_prev_q);
  assign sh.sclk_fall = rise_of(sclk_prev_q, sclk_s);
  assign sh.abort = device_reset || low_power;

  sda_shifter #(
    .WORD_BITS(WORD_BITS)
  ) u_shift (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sh(sh)
  );

  assign serial_out = sh.sdo;
  assign serial_out_oe = sh.busy;
  assign sclk_out = sh.sclk_o;
  assign sclk_oe = sh.busy && mode_s;
endmodule

// File: sda_ctrl_sva.sv
// checker for the converter serial control block
// assumes it is bound onto sda_ctrl and inherits its calibration length
`timescale 1ns/1ps
module sda_ctrl_sva #(
  parameter int CAL_CYCLES = 64
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // pins
  input wire logic self_clocked_mode,
  input wire logic trim_request,
  input wire logic conv_strobe,
  // outputs
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic serial_out_oe,
  input wire logic word_valid_n,
  input wire logic low_power,
  input wire logic device_reset,
  input wire logic trim_start,
  input wire logic trim_busy
);
  int oe_q;
  int bz_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // run lengths; long counts go in counters, not repetitions
  always_ff @(posedge ref_clk) begin
    oe_q <= serial_out_oe ? oe_q + 1 : 0;
  end
  always_ff @(posedge ref_clk) begin
    bz_q <= trim_busy ? bz_q + 1 : 0;
  end
  chk_load_gap: assert property (conv_strobe && !word_valid_n && !low_power && !trim_busy
    && !device_reset |=> word_valid_n [*4] ##1 !word_valid_n) else $error("load gap wrong");
  chk_sclk_duty: assert property ($rose(sclk_out) |=> !sclk_out [*3] ##1
    (sclk_out || !sclk_oe)) else $error("self clock shape wrong");
  chk_clk_dir: assert property (sclk_oe |-> self_clocked_mode)
    else $error("clock driven in external mode");
  chk_sleep_quiet: assert property (low_power && $past(low_power) |-> word_valid_n
    && !serial_out_oe && !sclk_oe) else $error("activity in sleep");
  chk_reset_len: assert property ($rose(device_reset) |-> $past(trim_request, 5))
    else $error("reset on short request");
  chk_cal_start: assert property ($fell(device_reset) |-> ##[0:2] trim_start)
    else $error("no calibration start");
  chk_start_once: assert property (trim_start |=> !trim_start)
    else $error("start not a pulse");
  chk_cal_len: assert property ($fell(trim_busy) |-> bz_q == CAL_CYCLES)
    else $error("calibration length wrong");
  chk_word_len: assert property (sclk_oe && serial_out_oe |-> oe_q < 80)
    else $error("word too long");
  chk_bit_bound: assert property ($fell(serial_out_oe) && $past(sclk_oe) |-> oe_q % 4 == 0)
    else $error("stop inside a bit");
  chk_done_valid: assert property ($fell(serial_out_oe) && oe_q == 80 |-> ##[0:1] word_valid_n)
    else $error("valid kept after word");
  cov_full_word: cover property ($fell(serial_out_oe) && oe_q == 80);
  cov_load: cover property (conv_strobe && !word_valid_n);
  cov_cal: cover property ($fell(trim_busy));
endmodule
bind sda_ctrl sda_ctrl_sva #(.CAL_CYCLES(CAL_CYCLES)) chk (.ref_clk(ref_clk), .nrst(nrst),
  .self_clocked_mode(self_clocked_mode), .trim_request(trim_request), .conv_strobe(conv_strobe),
  .sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_out_oe(serial_out_oe),
  .word_valid_n(word_valid_n), .low_power(low_power), .device_reset(device_reset),
  .trim_start(trim_start), .trim_busy(trim_busy));

// File: sda_host.sv
// host serial port model that reads words from the converter
// assumes the bench resolves the shared serial clock wire
`timescale 1ns/1ps
module sda_host (
  // clock
  input wire logic ref_clk,
  // serial wires
  input wire logic sd_o,
  input wire logic sd_oe,
  input wire logic sck_w,
  output logic sel_n,
  output logic sck_h
);
  logic last = 0;
  // a released data line shows no stale level
  wire sd = sd_oe ? sd_o : ~last;
  initial begin
    sel_n = 1;
    sck_h = 0;
  end
  always @(posedge ref_clk) last <= sd;
  task rd(input int n, input bit ext, output logic [19:0] w);
    int i;
    w = 20'h0_0000;
    sel_n = 0;
    if (ext) #407;
    for (i = 0; i < n; i++) begin
      if (ext) begin
        #160 sck_h = 1;
        #150 w = {w[18:0], sd};
        #10 sck_h = 0;
      end else begin
        @(negedge sck_w);
        w = {w[18:0], sd};
      end
    end
    if (ext) #200;
    // release just after a clock edge, like every other bench input
    @(posedge ref_clk);
    #1 sel_n = 1;
  endtask
endmodule

// File: sda_ctrl_bench.sv
// self-checking bench for the converter serial control block
// assumes checker and host model files are compiled first
`timescale 1ns/1ps
module sda_ctrl_bench;
  logic ref_clk = 0, nrst = 0, sleep_n = 1, pol = 0, mode = 1, trim = 0, ta = 0, tb = 0;
  logic strobe = 0, sck_o, sck_oe, sd_o, sd_oe, wv_n, lp, bip, dres, tst, tbusy, sel_n, sck_h;
  logic [19:0] cw = 20'h0_0000, w;
  logic [1:0] kind;
  int n_fail = 0, n_checks = 0, cyc = 0, i;
  wire sck_w = sck_oe ? sck_o : sck_h;
  sda_ctrl #(.CAL_CYCLES(4)) dut (.ref_clk(ref_clk), .nrst(nrst), .sleep_n(sleep_n),
    .polarity_select(pol), .self_clocked_mode(mode), .trim_request(trim), .trim_type_a(ta),
    .trim_type_b(tb), .device_select_n(sel_n), .sclk_in(sck_w), .sclk_out(sck_o),
    .sclk_oe(sck_oe), .serial_out(sd_o), .serial_out_oe(sd_oe), .word_valid_n(wv_n),
    .conv_word(cw), .conv_strobe(strobe), .low_power(lp), .bipolar_mode(bip),
    .device_reset(dres), .trim_start(tst), .trim_busy(tbusy), .trim_kind(kind));
  sda_host host (.ref_clk(ref_clk), .sd_o(sd_o), .sd_oe(sd_oe), .sck_w(sck_w), .sel_n(sel_n),
    .sck_h(sck_h));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task stop_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("mismatch at %0t: run hung", $time);
      stop_test();
    end
  end
  task chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // expected coding: offset binary when bipolar, negatives clamp when unipolar
  function logic [19:0] code(input logic [19:0] v, input logic b);
    return b ? {~v[19], v[18:0]} : (v[19] ? 20'h0_0000 : v);
  endfunction
  task load(input logic [19:0] v);
    cw = v;
    strobe = 1;
    tick(1);
    strobe = 0;
    tick(6);
  endtask
  task read(input int n, input logic [19:0] exp);
    host.rd(n, !mode, w);
    tick(12);
    chk(w, exp >> (20 - n));
  endtask
  initial begin
    tick(5);
    nrst = 1;
    pol = 1;
    tick(6);
    chk(bip, 1);
    load(20'h8_0001);
    chk(wv_n, 0);
    read(20, code(20'h8_0001, 1));
    chk(wv_n, 1);
    pol = 0;
    mode = 0;
    tick(6);
    chk(bip, 0);
    load(20'h8_0001);
    load(20'h1_2345);
    read(20, code(20'h1_2345, 0));
    chk(wv_n, 1);
    load(20'hF_0000);
    read(20, code(20'hF_0000, 0));
    mode = 1;
    tick(6);
    cw = 20'h0_0F0F;
    strobe = 1;
    tick(1);
    strobe = 0;
    tick(1);
    load(20'h7_0000);
    read(5, 20'h0_0F0F);
    chk(wv_n, 0);
    sleep_n = 0;
    tick(6);
    chk({lp, wv_n}, 2'b11);
    sleep_n = 1;
    tick(6);
    chk(lp, 0);
    // host pulses the request for three cycles, too short to reset the part
    trim = 1;
    tick(3);
    trim = 0;
    tick(12);
    chk(dres, 0);
    ta = 1;
    tick(6);
    trim = 1;
    tick(12);
    chk(dres, 1);
    chk(kind, 2'b01);
    trim = 0;
    ta = 0;
    for (i = 0; i < 20 && tbusy !== 1'b1; i++) tick(1);
    chk({dres, tbusy}, 2'b01);
    tick(8);
    chk(tbusy, 0);
    stop_test();
  end
endmodule
